// ==== rtl/adc_ctl_params.svh ====
`ifndef ADC_CTL_PARAMS_SVH
`define ADC_CTL_PARAMS_SVH
// Byte offsets on the register bus
`define OFF_CSR       12'h000
`define OFF_CTRL      12'h004
`define OFF_RESULT0   12'h020
`define OFF_IRQ_STAT  12'h010
`define OFF_IRQ_MASK  12'h014
// Control/status field positions
`define CSR_END_BIT   7
`define CSR_IE_BIT    6
`define CSR_START_BIT 5
`define CSR_RSVD_BIT  4
// Control register field positions
`define CTRL_SCAN_EN  1
`define CTRL_SCAN_SEL 0
// Reset values
`define CSR_RESET     8'h00
`define CTRL_RESET    2'h0
// Result placement
`define RES_LSB       6
`endif

// ==== rtl/adc_ctl_pkg.sv ====
package adc_ctl_pkg;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_CONV = 2'b01
  } conv_state_t;

  // Request to the analog core
  typedef struct packed {
    logic       start;
    logic [3:0] chan;
  } core_req_t;

  // Answer from the analog core
  typedef struct packed {
    logic       done;
    logic [9:0] data;
  } core_rsp_t;
endpackage

// ==== rtl/adc_control_status_logic.sv ====
// The implementer's own choices: the placing of the registers and register access over AHB-Lite.
`include "adc_ctl_params.svh"
`timescale 1ns/100ps
`default_nettype none
module adc_control_status_logic #(
  parameter int NCHAN = 12
) (
  input  wire logic                  hclk,
  input  wire logic                  hresetn,
  input  wire logic                  hsel,
  input  wire logic [11:0]           haddr,
  input  wire logic [1:0]            htrans,
  input  wire logic                  hwrite,
  input  wire logic [2:0]            hsize,
  input  wire logic [31:0]           hwdata,
  input  wire logic                  hready,
  output logic      [31:0]           hrdata,
  output logic                       hreadyout,
  output logic                       hresp,
  input  wire logic                  pulse_timer_unit_trig,
  input  wire logic                  byte_timer_trig,
  output adc_ctl_pkg::core_req_t     core_req,
  input  wire adc_ctl_pkg::core_rsp_t core_rsp,
  output logic                       conv_end_interrupt,
  output logic                       irq
);
  import adc_ctl_pkg::*;

  // Address phase capture
  logic        ap_valid;
  logic        ap_write;
  logic [11:0] ap_addr;
  logic        next_ap_valid;
  logic        next_ap_write;
  logic [11:0] next_ap_addr;

  // Register state
  logic        conv_end_flag;
  logic        conv_end_irq_enable;
  logic        conv_start_bit;
  logic [3:0]  chan_select;
  logic        scan_enable;
  logic        scan_group_select;
  logic        flag_seen_one;
  logic [1:0]  irq_stat;
  logic [1:0]  irq_mask;
  conv_state_t state;
  logic [3:0]  cur_chan;
  logic [15:0] result [NCHAN];
  logic        core_start;
  logic [31:0] rdata;

  logic        next_conv_end_flag;
  logic        next_conv_end_irq_enable;
  logic        next_conv_start_bit;
  logic [3:0]  next_chan_select;
  logic        next_scan_enable;
  logic        next_scan_group_select;
  logic        next_flag_seen_one;
  logic [1:0]  next_irq_stat;
  logic [1:0]  next_irq_mask;
  conv_state_t next_state;
  logic [3:0]  next_cur_chan;
  logic        next_core_start;
  logic [31:0] next_rdata;

  // Timer triggers come from other logic on hclk
  logic trig;
  assign trig = pulse_timer_unit_trig | byte_timer_trig;

  // First channel of the group picked by the select field
  function automatic logic [3:0] group_first(input logic [3:0] sel, input logic scn,
                                             input logic gsel);
    if (!scn || sel[3])
      group_first = scn ? 4'h8 : sel;
    else if (gsel)
      group_first = 4'h0;
    else
      group_first = {2'b00, sel[2], 1'b0} << 1;
    if (!scn)
      group_first = sel;
  endfunction

  // Decoded register hits in the data phase
  logic wr_csr;
  logic rd_csr;
  logic wr_ctrl;
  logic wr_stat;
  logic wr_mask;
  logic last_in_group;
  logic done_evt;
  assign wr_csr  = ap_valid && ap_write && ap_addr == `OFF_CSR;
  assign rd_csr  = ap_valid && !ap_write && ap_addr == `OFF_CSR;
  assign wr_ctrl = ap_valid && ap_write && ap_addr == `OFF_CTRL;
  assign wr_stat = ap_valid && ap_write && ap_addr == `OFF_IRQ_STAT;
  assign wr_mask = ap_valid && ap_write && ap_addr == `OFF_IRQ_MASK;
  assign done_evt = state == ST_CONV && core_rsp.done && conv_start_bit;
  // Group ends where the select field points
  assign last_in_group = !scan_enable || cur_chan == chan_select;

  // Bus slave: zero wait states, always OKAY
  always_comb begin
    next_ap_valid = ap_valid;
    next_ap_write = ap_write;
    next_ap_addr  = ap_addr;
    if (hready) begin
      next_ap_valid = hsel && htrans[1];
      next_ap_write = hwrite;
      next_ap_addr  = {haddr[11:2], 2'b00};
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_valid <= 1'b0;
      ap_write <= 1'b0;
      ap_addr  <= 12'h000;
    end else begin
      ap_valid <= next_ap_valid;
      ap_write <= next_ap_write;
      ap_addr  <= next_ap_addr;
    end
  end

  // Read mux; reads settle one cycle after the address phase
  always_comb begin
    next_rdata = 32'h0000_0000;
    if (hready && hsel && htrans[1] && !hwrite) begin
      case ({haddr[11:2], 2'b00})
        `OFF_CSR:      next_rdata = {24'h00_0000, next_conv_end_flag, next_conv_end_irq_enable,
                                     next_conv_start_bit, 1'b0, next_chan_select};
        `OFF_CTRL:     next_rdata = {30'h0000_0000, next_scan_enable, next_scan_group_select};
        `OFF_IRQ_STAT: next_rdata = {30'h0000_0000, next_irq_stat};
        `OFF_IRQ_MASK: next_rdata = {30'h0000_0000, next_irq_mask};
        default: begin
          if (haddr >= `OFF_RESULT0 && haddr < `OFF_RESULT0 + 12'(4 * NCHAN))
            // Word index counted from the first result slot, not from address zero
            next_rdata = {16'h0000, result[4'(haddr[6:2] - 5'h08)]};
        end
      endcase
    end
  end

  // Control/status and conversion sequencing
  always_comb begin
    next_conv_end_flag       = conv_end_flag;
    next_conv_end_irq_enable = conv_end_irq_enable;
    next_conv_start_bit      = conv_start_bit;
    next_chan_select         = chan_select;
    next_scan_enable         = scan_enable;
    next_scan_group_select   = scan_group_select;
    next_flag_seen_one       = flag_seen_one;
    next_irq_stat            = irq_stat;
    next_irq_mask            = irq_mask;
    next_state               = state;
    next_cur_chan            = cur_chan;
    next_core_start          = 1'b0;
    // Arm clearing only after software has seen the flag high
    if (rd_csr && conv_end_flag)
      next_flag_seen_one = 1'b1;
    if (wr_csr) begin
      if (!hwdata[`CSR_END_BIT] && flag_seen_one) begin
        next_conv_end_flag = 1'b0;
        next_flag_seen_one = 1'b0;
      end
      next_conv_end_irq_enable = hwdata[`CSR_IE_BIT];
      next_conv_start_bit      = hwdata[`CSR_START_BIT];
      // Field is only safe to change while halted; written anyway
      next_chan_select         = hwdata[3:0];
    end
    if (wr_ctrl) begin
      next_scan_enable       = hwdata[`CTRL_SCAN_EN];
      next_scan_group_select = hwdata[`CTRL_SCAN_SEL];
    end
    if (trig)
      next_conv_start_bit = 1'b1;
    case (state)
      ST_IDLE: begin
        if (next_conv_start_bit && !conv_start_bit) begin
          next_state      = ST_CONV;
          next_cur_chan   = group_first(next_chan_select, next_scan_enable,
                                        next_scan_group_select);
          next_core_start = 1'b1;
        end
      end
      ST_CONV: begin
        if (!next_conv_start_bit) begin
          next_state = ST_IDLE;
        end else if (core_rsp.done) begin
          if (last_in_group) begin
            next_conv_end_flag = 1'b1;
            next_irq_stat[0]   = 1'b1;
          end
          if (!scan_enable) begin
            next_conv_start_bit = 1'b0;
            next_state          = ST_IDLE;
          end else begin
            // Wrap to group start and keep going
            next_cur_chan   = last_in_group ? group_first(chan_select, scan_enable,
                                                          scan_group_select)
                                            : cur_chan + 4'h1;
            next_core_start = 1'b1;
          end
        end
      end
      default: next_state = ST_IDLE;
    endcase
    // Write-one clear; a same-cycle event wins on bit 1, but bit 0 still clears if it was already set
    if (wr_stat)
      next_irq_stat = next_irq_stat & ~(hwdata[1:0] & irq_stat);
    if (done_evt)
      next_irq_stat[1] = 1'b1;
    if (wr_mask)
      next_irq_mask = hwdata[1:0];
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      conv_end_flag       <= 1'b0;
      conv_end_irq_enable <= 1'b0;
      conv_start_bit      <= 1'b0;
      chan_select         <= 4'h0;
      scan_enable         <= 1'b0;
      scan_group_select   <= 1'b0;
      flag_seen_one       <= 1'b0;
      irq_stat            <= 2'h0;
      irq_mask            <= 2'h0;
      state               <= ST_IDLE;
      cur_chan            <= 4'h0;
      core_start          <= 1'b0;
      rdata               <= 32'h0000_0000;
    end else begin
      conv_end_flag       <= next_conv_end_flag;
      conv_end_irq_enable <= next_conv_end_irq_enable;
      conv_start_bit      <= next_conv_start_bit;
      chan_select         <= next_chan_select;
      scan_enable         <= next_scan_enable;
      scan_group_select   <= next_scan_group_select;
      flag_seen_one       <= next_flag_seen_one;
      irq_stat            <= next_irq_stat;
      irq_mask            <= next_irq_mask;
      state               <= next_state;
      cur_chan            <= next_cur_chan;
      core_start          <= next_core_start;
      rdata               <= next_rdata;
    end
  end

  // Result store, one word per channel, low six bits zero
  genvar g;
  generate
    for (g = 0; g < NCHAN; g++) begin : g_res
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
          result[g] <= 16'h0000;
        else if (done_evt && cur_chan == 4'(g))
          result[g] <= {core_rsp.data, 6'h00};
      end
    end
  endgenerate

  // Registered outputs
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      conv_end_interrupt <= 1'b0;
      irq                <= 1'b0;
      core_req           <= '0;
    end else begin
      conv_end_interrupt <= next_conv_end_flag & next_conv_end_irq_enable;
      irq                <= |(next_irq_stat & next_irq_mask);
      core_req.start     <= next_core_start;
      core_req.chan      <= next_cur_chan;
    end
  end

  assign hrdata    = rdata;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
endmodule
`default_nettype wire

// ==== verification/adc_ctl_monitor.sv ====
`timescale 1ns/100ps
`default_nettype none
module adc_ctl_monitor (
  input wire logic                   hclk,
  input wire logic                   hresetn,
  input wire logic                   hsel,
  input wire logic [1:0]             htrans,
  input wire logic                   hwrite,
  input wire logic                   hready,
  input wire logic                   pulse_timer_unit_trig,
  input wire logic                   byte_timer_trig,
  input wire adc_ctl_pkg::core_req_t core_req,
  input wire adc_ctl_pkg::core_rsp_t core_rsp,
  input wire logic                   conv_end_interrupt,
  input wire logic                   irq
);
  import adc_ctl_pkg::*;
  logic wr_dp;
  logic cause;
  logic seen;
  logic next_wr_dp;
  logic next_cause;
  logic next_seen;
  // Write data phases and pending launch causes; loose on purpose
  always_comb begin
    next_wr_dp = hsel & htrans[1] & hwrite & hready;
    next_cause = (cause & ~core_req.start) | wr_dp | pulse_timer_unit_trig
               | byte_timer_trig | core_rsp.done;
    next_seen  = seen | core_rsp.done;
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_dp <= 1'b0;
      cause <= 1'b0;
      seen  <= 1'b0;
    end else begin
      wr_dp <= next_wr_dp;
      cause <= next_cause;
      seen  <= next_seen;
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_pt_trig_start: assert property (pulse_timer_unit_trig |-> ##[1:3] core_req.start)
    else $error("timer trigger gave no request");
  a_bt_trig_start: assert property (byte_timer_trig |-> ##[1:3] core_req.start)
    else $error("byte timer trigger gave no request");
  a_req_has_cause: assert property (core_req.start |-> cause)
    else $error("request without a cause");
  a_req_one_cycle: assert property (core_req.start |=> !core_req.start)
    else $error("request held too long");
  a_chan_with_req: assert property ($changed(core_req.chan) |-> core_req.start)
    else $error("channel changed without request");
  a_end_irq_cause: assert property (conv_end_interrupt |-> seen)
    else $error("end interrupt before any conversion");
  a_irq_cause: assert property (irq |-> seen)
    else $error("irq before any conversion");
  a_end_irq_drop: assert property ($fell(conv_end_interrupt)
      |-> $past(wr_dp) || $past(wr_dp, 2) || $past(wr_dp, 3))
    else $error("end interrupt fell without a write");
  a_irq_drop: assert property ($fell(irq)
      |-> $past(wr_dp) || $past(wr_dp, 2) || $past(wr_dp, 3))
    else $error("irq fell without a write");
  a_reset_quiet: assert property ($rose(hresetn)
      |-> !core_req.start && !conv_end_interrupt && !irq)
    else $error("outputs active after reset");
  c_scan_next: cover property (core_rsp.done ##[1:3] core_req.start);
  c_end_irq: cover property ($rose(conv_end_interrupt));
  c_irq: cover property ($rose(irq));
endmodule
`default_nettype wire

// ==== verification/adc_control_status_logic_tb.sv ====
`include "adc_ctl_params.svh"
`timescale 1ns/100ps
`default_nettype none
module adc_control_status_logic_tb;
  import adc_ctl_pkg::*;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic        hwrite = 1'b0;
  logic        pt_trig = 1'b0;
  logic        bt_trig = 1'b0;
  logic [11:0] haddr = 12'h000;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic [31:0] rd;
  logic        hreadyout;
  logic        hresp;
  logic        conv_end_interrupt;
  logic        irq;
  core_req_t   core_req;
  core_rsp_t   core_rsp = '0;
  int          n_fail = 0;
  int          checks_done = 0;
  int          cycles = 0;
  adc_control_status_logic adc_control_status_logic_i (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .pulse_timer_unit_trig(pt_trig), .byte_timer_trig(bt_trig), .core_req(core_req),
    .core_rsp(core_rsp), .conv_end_interrupt(conv_end_interrupt), .irq(irq));
  // Clock, and a hang guard far above the sequence length
  always #2.5 hclk = ~hclk;
  always @(posedge hclk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      n_fail++;
      print_verdict();
    end
  end
  task automatic print_verdict();
    $display("Checks %0d, mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  // Single word transfer; no fixed latency assumed in either phase
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    check(rd, exp);
  endtask
  // Bounded wait for a core request, then its channel
  task automatic wait_req(input logic [3:0] ch);
    int i;
    i = 0;
    do begin
      @(posedge hclk);
      i++;
    end while (core_req.start !== 1'b1 && i < 40);
    check(32'({core_req.start, core_req.chan}), 32'({1'b1, ch}));
  endtask
  task automatic done_pulse(input logic [9:0] d);
    @(posedge hclk);
    core_rsp <= {1'b1, d};
    @(posedge hclk);
    core_rsp <= '0;
  endtask
  task automatic pulse(input logic bt);
    @(posedge hclk);
    bt_trig <= bt;
    pt_trig <= ~bt;
    @(posedge hclk);
    bt_trig <= 1'b0;
    pt_trig <= 1'b0;
  endtask
  // A halted block must stay silent even if the core answers late
  task automatic no_req();
    logic seen_req;
    seen_req = 1'b0;
    repeat (12) begin
      @(posedge hclk);
      seen_req |= core_req.start;
    end
    check(32'(seen_req), 32'h0);
  endtask
  initial begin
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    rdchk(`OFF_CSR, 32'h0);
    bus(1'b1, `OFF_CSR, 32'h31);
    wait_req(4'h1);
    rdchk(`OFF_CSR, 32'h21);
    done_pulse(10'h2A5);
    rdchk(`OFF_CSR, 32'h81);
    rdchk(`OFF_RESULT0 + 12'h004, 32'hA940);
    check(32'(conv_end_interrupt), 32'h0);
    bus(1'b1, `OFF_CSR, 32'hC1);
    rdchk(`OFF_CSR, 32'hC1);
    check(32'(conv_end_interrupt), 32'h1);
    bus(1'b1, `OFF_CSR, 32'h41);
    rdchk(`OFF_CSR, 32'h41);
    check(32'(conv_end_interrupt), 32'h0);
    // Status stays hidden until the mask opens, then W1C drops it
    check(32'(irq), 32'h0);
    bus(1'b1, `OFF_IRQ_MASK, 32'h3);
    repeat (3) @(posedge hclk);
    check(32'(irq), 32'h1);
    bus(1'b1, `OFF_IRQ_STAT, 32'h3);
    repeat (3) @(posedge hclk);
    check(32'(irq), 32'h0);
    // Zero write without a prior read must not clear the flag
    pulse(1'b1);
    wait_req(4'h1);
    done_pulse(10'h155);
    bus(1'b1, `OFF_CSR, 32'h41);
    rdchk(`OFF_CSR, 32'hC1);
    bus(1'b1, `OFF_CSR, 32'h01);
    rdchk(`OFF_CSR, 32'h01);
    // Scan of inputs 0 and 1, repeating
    bus(1'b1, `OFF_CTRL, 32'h3);
    pulse(1'b0);
    wait_req(4'h0);
    done_pulse(10'h001);
    wait_req(4'h1);
    rdchk(`OFF_CSR, 32'h21);
    done_pulse(10'h3FF);
    wait_req(4'h0);
    rdchk(`OFF_CSR, 32'hA1);
    rdchk(`OFF_RESULT0 + 12'h004, 32'hFFC0);
    bus(1'b1, `OFF_CSR, 32'h01);
    done_pulse(10'h000);
    no_req();
    rdchk(`OFF_CSR, 32'h01);
    rdchk(12'h100, 32'h0);
    print_verdict();
  end
endmodule
bind adc_control_status_logic adc_ctl_monitor adc_ctl_monitor_i (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
  .hready(hready), .pulse_timer_unit_trig(pulse_timer_unit_trig),
  .byte_timer_trig(byte_timer_trig), .core_req(core_req), .core_rsp(core_rsp),
  .conv_end_interrupt(conv_end_interrupt), .irq(irq));
`default_nettype wire
